//--- rtl/tais_pkg.sv
// Constants for the timer 2 register, flag and asynchronous-update block.
// Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
package tais_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_IRQ_FLAGS    = 10'h037;
  localparam logic [9:0] IDX_GEN_CTRL     = 10'h043;
  localparam logic [9:0] IDX_CPU_STATUS   = 10'h05F;
  localparam logic [9:0] IDX_IRQ_MASK     = 10'h070;
  localparam logic [9:0] IDX_CTRL_A       = 10'h0B0;
  localparam logic [9:0] IDX_CTRL_B       = 10'h0B1;
  localparam logic [9:0] IDX_COUNT        = 10'h0B2;
  localparam logic [9:0] IDX_CMP_A        = 10'h0B3;
  localparam logic [9:0] IDX_CMP_B        = 10'h0B4;
  localparam logic [9:0] IDX_ASYNC_STATUS = 10'h0B6;

  // Flag, enable and request bit positions
  localparam int FLAG_CMP_B = 2;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_OVF   = 0;

  // Async status, general control and global enable bit positions
  localparam int ASY_EXT_CLK   = 6;
  localparam int ASY_CLK_SEL   = 5;
  localparam int GTC_SYNC_MODE = 7;
  localparam int GTC_PSR_ASYNC = 1;
  localparam int GTC_PSR_SYNC  = 0;
  localparam int GIE_BIT       = 7;

  // Slots of the staged registers; also the busy bit positions
  localparam int SLOT_COUNT  = 4;
  localparam int SLOT_CMP_A  = 3;
  localparam int SLOT_CMP_B  = 2;
  localparam int SLOT_CTRL_A = 1;
  localparam int SLOT_CTRL_B = 0;

  // Implemented bits of the two control registers
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0F;
  localparam logic [7:0] RST_REG     = 8'h00;

  // Counting sequence
  localparam logic [2:0] WGM_CTC      = 3'h2;
  localparam logic [2:0] WGM_FAST_TOP = 3'h7;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
  localparam logic [7:0] CNT_ONE      = 8'h01;
  localparam logic [9:0] PRESC_ONE    = 10'h001;

  // Prescaler tap per clock select: divide by 1,1,8,32,64,128,256,1024
  localparam logic [7:0][9:0] PRESC_MASK = {
    10'h3FF, 10'h0FF, 10'h07F, 10'h03F,
    10'h01F, 10'h007, 10'h000, 10'h000};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- rtl/tais_timer2.sv
// Timer 2 register side: compare B, interrupt mask and flags, async clock
// select with update-busy staging, prescaler reset, AXI4-Lite slave.
// Assumes one clock aclk; the oscillator pin is sampled in that domain.
//
// Notes on behaviour
// - Eight-bit compare B value is compared with the counter every tick.
// - Mask holds three enables at bits 2..0; upper bits read zero.
// - Compare B match sets flag bit 2.
// - Compare A match sets flag bit 1.
// - Flags clear on vector execution or on writing one.
// - Request needs global enable, its enable and its flag together.
// - Overflow sets bit 0; in phase PWM, reversal at bottom sets it.
// - External clock bit with async select set enables pin buffer; crystal runs only when external clock bit is zero.
// - Async select bit picks I/O clock or oscillator pin tick.
// - Changing async select may corrupt counter, compares and controls.
// - Async writes set busy until moved into the timer domain.
// - Busy bits sit at 4..0 of async status; bit 7 reads zero.
// - Counter reads live value; compares and controls read staging.
// - Prescaler reset clears at once, or after the reset in async mode.
// - Sync mode bit keeps the prescaler reset bit set.
// - Counter write blocks the compare match on the next timer tick.
module tais_timer2
  import tais_pkg::*;
(
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [11:0] s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [11:0] s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  input  logic        timer_osc_pin_1,
  input  logic [2:0]  vector_ack,
  output logic [2:0]  irq_req,
  output logic        irq,
  output logic        cmp_b_wave_pin,
  output logic        osc_input_buf_en,
  output logic        xtal_osc_en
);

  typedef struct packed {
    logic [4:0][7:0] stage;
    logic [3:0][7:0] active;
    logic [7:0]      count_value;
    logic [4:0]      busy;
    logic [2:0]      irq_flag_reg;
    logic [2:0]      irq_mask_reg;
    logic            gie;
    logic            ext_clk_input_en;
    logic            async_clock_select;
    logic            timer_sync_mode;
    logic            async_prescaler_reset;
    logic            sync_prescaler_reset;
    logic [9:0]      presc;
    logic            down;
    logic            block_match;
    logic            wave_b;
    logic            osc_s1;
    logic            osc_s2;
    logic            osc_s3;
    logic            aw_held;
    logic [9:0]      aw_idx;
    logic            w_held;
    logic [7:0]      wdata;
    logic            wlane;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [7:0]      rdata;
    logic [1:0]      rresp;
    logic [2:0]      irq_req;
    logic            buf_en;
    logic            xtal_en;
  } tais_state_t;

  localparam tais_state_t ST_RESET = '{xtal_en: 1'b1, default: '0};

  tais_state_t st;
  tais_state_t next_st;

  logic        base;
  logic        tick;
  logic [2:0]  cs;
  logic [9:0]  pm;
  logic [2:0]  wgm;
  logic [7:0]  top;
  logic        phase;
  logic        fast;
  logic [1:0]  com_b;
  logic        aw_fire;
  logic        w_fire;
  logic        ar_fire;
  logic        wr_go;
  logic        wr;
  logic [9:0]  wr_idx;
  logic [7:0]  d;
  logic [2:0]  set_f;
  logic [2:0]  clr_f;
  logic [7:0]  rd;
  logic [9:0]  rd_idx;

  function automatic logic mapped(input logic [9:0] idx);
    case (idx)
      IDX_IRQ_FLAGS, IDX_GEN_CTRL, IDX_CPU_STATUS, IDX_IRQ_MASK,
      IDX_CTRL_A, IDX_CTRL_B, IDX_COUNT, IDX_CMP_A, IDX_CMP_B,
      IDX_ASYNC_STATUS: mapped = 1'b1;
      default:          mapped = 1'b0;
    endcase
  endfunction

  // Slots follow the busy bit order, not the address order, so the
  // register index of each slot is spelled out rather than computed
  function automatic logic [9:0] slot_idx(input int slot);
    case (slot)
      SLOT_COUNT:  slot_idx = IDX_COUNT;
      SLOT_CMP_A:  slot_idx = IDX_CMP_A;
      SLOT_CMP_B:  slot_idx = IDX_CMP_B;
      SLOT_CTRL_A: slot_idx = IDX_CTRL_A;
      default:     slot_idx = IDX_CTRL_B;
    endcase
  endfunction

  assign s_axi_awready    = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready     = ~st.w_held & ~st.bvalid;
  assign s_axi_arready    = ~st.rvalid;
  assign s_axi_bvalid     = st.bvalid;
  assign s_axi_bresp      = st.bresp;
  assign s_axi_rvalid     = st.rvalid;
  assign s_axi_rresp      = st.rresp;
  assign s_axi_rdata      = {24'h000000, st.rdata};
  assign irq_req          = st.irq_req;
  assign irq              = |st.irq_req;
  assign cmp_b_wave_pin   = st.wave_b;
  assign osc_input_buf_en = st.buf_en;
  assign xtal_osc_en      = st.xtal_en;

  always_comb begin
    next_st = st;
    set_f   = 3'h0;
    clr_f   = vector_ack;

    ////////////////////////////////////////////////////////////////////////
    // Timer clock base: the oscillator pin passes two flops, a third only
    // feeds the edge detector, so no logic reads a metastable sample
    next_st.osc_s1 = timer_osc_pin_1;
    next_st.osc_s2 = st.osc_s1;
    next_st.osc_s3 = st.osc_s2;
    base = st.async_clock_select ?
           (st.osc_s2 & ~st.osc_s3) : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and counter
    cs   = st.active[SLOT_CTRL_B][2:0];
    pm   = PRESC_MASK[cs];
    tick = base & (cs != 3'h0) & ((st.presc & pm) == pm);
    if (st.async_prescaler_reset) begin
      next_st.presc = 10'h000;
    end else if (base) begin
      next_st.presc = st.presc + PRESC_ONE;
    end

    wgm   = {st.active[SLOT_CTRL_B][3], st.active[SLOT_CTRL_A][1:0]};
    top   = (wgm == WGM_CTC || wgm[2]) ? st.active[SLOT_CMP_A] : CNT_MAX;
    phase = wgm[0] & ~wgm[1];
    fast  = &wgm[1:0];
    com_b = st.active[SLOT_CTRL_A][5:4];

    if (tick) begin
      next_st.block_match = 1'b0;
      if (!st.block_match) begin
        if (st.count_value == st.active[SLOT_CMP_A]) begin
          set_f[FLAG_CMP_A] = 1'b1;
        end
        if (st.count_value == st.active[SLOT_CMP_B]) begin
          set_f[FLAG_CMP_B] = 1'b1;
          if (phase && com_b[1]) begin
            next_st.wave_b = com_b[0] ^ st.down;
          end else if (fast && com_b[1]) begin
            next_st.wave_b = com_b[0];
          end else if (!phase && !fast) begin
            case (com_b)
              2'h1:    next_st.wave_b = ~st.wave_b;
              2'h2:    next_st.wave_b = 1'b0;
              2'h3:    next_st.wave_b = 1'b1;
              default: next_st.wave_b = st.wave_b;
            endcase
          end
        end
      end
      if (phase) begin
        if (!st.down) begin
          if (st.count_value == top) begin
            next_st.down        = 1'b1;
            next_st.count_value = st.count_value - CNT_ONE;
          end else begin
            next_st.count_value = st.count_value + CNT_ONE;
          end
        end else if (st.count_value == CNT_BOTTOM) begin
          next_st.down         = 1'b0;
          next_st.count_value  = CNT_ONE;
          set_f[FLAG_OVF]      = 1'b1;
        end else begin
          next_st.count_value = st.count_value - CNT_ONE;
        end
      end else begin
        next_st.down = 1'b0;
        if (st.count_value == top) begin
          next_st.count_value = CNT_BOTTOM;
          if (top == CNT_MAX || wgm == WGM_FAST_TOP) begin
            set_f[FLAG_OVF] = 1'b1;
          end
          if (fast && com_b[1]) begin
            next_st.wave_b = ~com_b[0];
          end
        end else begin
          next_st.count_value = st.count_value + CNT_ONE;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Staged registers move into the timer domain on the timer clock edge
    // that follows the write; busy drops in that same cycle
    for (int i = 0; i < 5; i++) begin
      if (base && st.busy[i]) begin
        next_st.busy[i] = 1'b0;
        if (i == SLOT_COUNT) begin
          next_st.count_value = st.stage[i];
          next_st.block_match = 1'b1;
        end else begin
          next_st.active[i] = st.stage[i];
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler reset release: a reset in async mode is done on the next
    // oscillator edge; sync mode holds it
    if (st.async_prescaler_reset && !st.timer_sync_mode &&
        (!st.async_clock_select || base)) begin
      next_st.async_prescaler_reset = 1'b0;
    end
    if (st.sync_prescaler_reset && !st.timer_sync_mode) begin
      next_st.sync_prescaler_reset = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken in either order
    aw_fire = s_axi_awvalid & s_axi_awready;
    w_fire  = s_axi_wvalid & s_axi_wready;
    if (aw_fire) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx  = s_axi_awaddr[11:2];
    end
    if (w_fire) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata[7:0];
      next_st.wlane  = s_axi_wstrb[0];
    end
    wr_go  = (st.aw_held | aw_fire) & (st.w_held | w_fire);
    wr_idx = st.aw_held ? st.aw_idx : s_axi_awaddr[11:2];
    d      = st.w_held ? st.wdata : s_axi_wdata[7:0];
    wr     = wr_go & (st.w_held ? st.wlane : s_axi_wstrb[0]);
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // A write while busy simply restages; the result is not guaranteed
    if (wr) begin
      case (wr_idx)
        IDX_IRQ_FLAGS:  clr_f = clr_f | d[2:0];
        IDX_IRQ_MASK:   next_st.irq_mask_reg = d[2:0];
        IDX_CPU_STATUS: next_st.gie = d[GIE_BIT];
        IDX_GEN_CTRL: begin
          next_st.timer_sync_mode = d[GTC_SYNC_MODE];
          if (d[GTC_PSR_ASYNC]) begin
            next_st.async_prescaler_reset = 1'b1;
          end
          if (d[GTC_PSR_SYNC]) begin
            next_st.sync_prescaler_reset = 1'b1;
          end
        end
        IDX_ASYNC_STATUS: begin
          // Contents of the timer may be lost on a clock switch
          next_st.ext_clk_input_en   = d[ASY_EXT_CLK];
          next_st.async_clock_select = d[ASY_CLK_SEL];
        end
        IDX_CTRL_A, IDX_CTRL_B, IDX_COUNT, IDX_CMP_A, IDX_CMP_B: begin
          for (int i = 0; i < 5; i++) begin
            if (wr_idx == slot_idx(i)) begin
              next_st.stage[i] = d;
              if (st.async_clock_select) begin
                next_st.busy[i] = 1'b1;
              end else if (i == SLOT_COUNT) begin
                next_st.count_value = d;
                next_st.block_match = 1'b1;
              end else begin
                next_st.active[i] = d;
              end
            end
          end
        end
        default: ;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read, answered one cycle after the address is taken
    ar_fire = s_axi_arvalid & ~st.rvalid;
    rd_idx  = s_axi_araddr[11:2];
    case (rd_idx)
      IDX_IRQ_FLAGS:    rd = {5'h00, st.irq_flag_reg};
      IDX_IRQ_MASK:     rd = {5'h00, st.irq_mask_reg};
      IDX_CPU_STATUS:   rd = {st.gie, 7'h00};
      IDX_GEN_CTRL:     rd = {st.timer_sync_mode, 5'h00,
                              st.async_prescaler_reset,
                              st.sync_prescaler_reset};
      IDX_ASYNC_STATUS: rd = {1'b0, st.ext_clk_input_en,
                              st.async_clock_select, st.busy};
      IDX_COUNT:        rd = st.count_value;
      IDX_CMP_A:        rd = st.stage[SLOT_CMP_A];
      IDX_CMP_B:        rd = st.stage[SLOT_CMP_B];
      IDX_CTRL_A:       rd = st.stage[SLOT_CTRL_A] & CTRL_A_MASK;
      IDX_CTRL_B:       rd = st.stage[SLOT_CTRL_B] & CTRL_B_MASK;
      default:          rd = RST_REG;
    endcase
    if (ar_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
      next_st.rresp  = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: a set in the same cycle as a clear wins
    next_st.irq_flag_reg = (st.irq_flag_reg & ~clr_f) | set_f;
    next_st.irq_req = {3{next_st.gie}} & next_st.irq_flag_reg
                      & next_st.irq_mask_reg;
    next_st.buf_en  = next_st.ext_clk_input_en &
                      next_st.async_clock_select;
    next_st.xtal_en = ~next_st.ext_clk_input_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule

//--- verification/tais_timer2_sva.sv
// Checker for the timer 2 register block: bus handshakes, interrupt
// request output and oscillator pin controls. Sees only top-level ports.
module tais_timer2_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  irq_req,
  input wire logic        irq,
  input wire logic        osc_input_buf_en,
  input wire logic        xtal_osc_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  irq_is_or_a: assert property (irq == (|irq_req))
    else $error("irq differs from OR of requests");
  // External buffer and crystal must never run together
  osc_exclusive_a: assert property (
    osc_input_buf_en |-> !xtal_osc_en)
    else $error("buffer and crystal both enabled");
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid)
    else $error("no write response after write taken");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data after read taken");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  busy_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during pending response");
  irq_seen_c: cover property ($rose(irq));
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  buf_on_c: cover property ($rose(osc_input_buf_en));
endmodule

bind tais_timer2 tais_timer2_sva chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq_req(irq_req), .irq(irq), .osc_input_buf_en(osc_input_buf_en),
  .xtal_osc_en(xtal_osc_en));

//--- verification/test_timer2_async_irq_status.sv
// Self-checking bench for the timer 2 register block over AXI4-Lite.
// Assumes the bound checker; the oscillator pin is pulsed by the bench.
module test_timer2_async_irq_status
  import tais_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, pin = 0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [2:0]  ack = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, wave, buf_en;
  logic        xtal;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  irq_req;
  int          n_mismatch = 0, comparisons = 0;
  always #10 aclk = ~aclk;
  tais_timer2 DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_osc_pin_1(pin), .vector_ack(ack),
    .irq_req(irq_req), .irq(irq), .cmp_b_wave_pin(wave),
    .osc_input_buf_en(buf_en), .xtal_osc_en(xtal));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    logic [1:0] r;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr  <= {idx, 2'h0};
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    wdata   <= {24'h0, d};
    wstrb   <= 4'hF;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 0;
        n = 99;
      end
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e,
                    input logic [1:0] er);
    int n;
    logic [31:0] d;
    logic [1:0]  r;
    n = 0;
    d = 32'hX;
    r = 2'h3;
    @(posedge aclk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1;
    rready  <= 1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 0;
        n = 99;
      end
    end
    chk("rdata", {24'h0, e}, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  // One rising edge of the oscillator pin, then time to synchronise
  task automatic osc_tick();
    @(posedge aclk) pin <= 1;
    repeat (4) @(posedge aclk);
    pin <= 0;
    repeat (6) @(posedge aclk);
  endtask
  task automatic run_timer(input int n);
    wr(IDX_CTRL_B, 8'h01, RESP_OKAY);
    repeat (n) @(posedge aclk);
    wr(IDX_CTRL_B, 8'h00, RESP_OKAY);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    chk("xtal", 1, xtal);
    rd(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    rd(IDX_ASYNC_STATUS, 8'h00, RESP_OKAY);
    rd(IDX_GEN_CTRL, 8'h00, RESP_OKAY);
    rd(10'h3FF, 8'h00, RESP_SLVERR);
    wr(10'h3FF, 8'hFF, RESP_SLVERR);
    wr(IDX_IRQ_MASK, 8'hFF, RESP_OKAY);
    rd(IDX_IRQ_MASK, 8'h07, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    // Compare values far apart so one short run hits both, not overflow
    wr(IDX_CMP_A, 8'h20, RESP_OKAY);
    wr(IDX_CMP_B, 8'h10, RESP_OKAY);
    rd(IDX_CMP_B, 8'h10, RESP_OKAY);
    wr(IDX_COUNT, 8'h00, RESP_OKAY);
    wr(IDX_CTRL_A, 8'h10, RESP_OKAY);
    run_timer(40);
    rd(IDX_IRQ_FLAGS, 8'h06, RESP_OKAY);
    // Compare B output toggles once on its single match
    chk("wave", 1, wave);
    wr(IDX_IRQ_FLAGS, 8'h04, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 8'h02, RESP_OKAY);
    wr(IDX_IRQ_FLAGS, 8'h00, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 8'h02, RESP_OKAY);
    @(posedge aclk) ack <= 3'h2;
    @(posedge aclk) ack <= 3'h0;
    rd(IDX_IRQ_FLAGS, 8'h00, RESP_OKAY);
    // A counter write sitting on compare B must not raise its match
    wr(IDX_COUNT, 8'h10, RESP_OKAY);
    run_timer(2);
    rd(IDX_IRQ_FLAGS, 8'h00, RESP_OKAY);
    chk("wave", 1, wave);
    // Wrap from near the top stops short of compare B
    wr(IDX_COUNT, 8'hF8, RESP_OKAY);
    run_timer(10);
    rd(IDX_IRQ_FLAGS, 8'h01, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 0, irq);
    wr(IDX_CPU_STATUS, 8'h80, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq_req", 1, irq_req);
    chk("irq", 1, irq);
    wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 0, irq);
    wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
    wr(IDX_IRQ_FLAGS, 8'h01, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 0, irq);
    // Phase correct, compare A as top: overflow only at the bottom turn
    wr(IDX_CMP_A, 8'h04, RESP_OKAY);
    wr(IDX_CTRL_A, 8'h01, RESP_OKAY);
    wr(IDX_COUNT, 8'h00, RESP_OKAY);
    wr(IDX_CTRL_B, 8'h09, RESP_OKAY);
    repeat (12) @(posedge aclk);
    wr(IDX_CTRL_B, 8'h08, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 8'h03, RESP_OKAY);
    wr(IDX_IRQ_FLAGS, 8'h03, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 8'h00, RESP_OKAY);
    // External clock bit first, then async select
    wr(IDX_ASYNC_STATUS, 8'h40, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("buf_en", 0, buf_en);
    chk("xtal", 0, xtal);
    wr(IDX_ASYNC_STATUS, 8'h60, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("buf_en", 1, buf_en);
    rd(IDX_ASYNC_STATUS, 8'h60, RESP_OKAY);
    wr(IDX_CMP_B, 8'h55, RESP_OKAY);
    rd(IDX_ASYNC_STATUS, 8'h64, RESP_OKAY);
    rd(IDX_CMP_B, 8'h55, RESP_OKAY);
    osc_tick();
    rd(IDX_ASYNC_STATUS, 8'h60, RESP_OKAY);
    wr(IDX_GEN_CTRL, 8'h02, RESP_OKAY);
    rd(IDX_GEN_CTRL, 8'h02, RESP_OKAY);
    osc_tick();
    rd(IDX_GEN_CTRL, 8'h00, RESP_OKAY);
    wr(IDX_GEN_CTRL, 8'h82, RESP_OKAY);
    osc_tick();
    rd(IDX_GEN_CTRL, 8'h82, RESP_OKAY);
    tally_and_finish();
  end
endmodule
